// ==== src/cafc_pkg.sv ====
// Package with the register map, field layouts and carriers of the acceptance filter block.
package cafc_pkg;

  // Bus geometry.
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          NUM_FILTERS  = 8;
  localparam int          BANK_BYTES   = 8;
  localparam int          HALF_BYTES   = 4;
  localparam int          BANK_TOTAL   = NUM_FILTERS * BANK_BYTES;
  localparam int          BANK_IDX_W   = 6;

  // Register byte addresses.
  localparam logic [11:0] OFS_MODE_LO  = 12'h000;
  localparam logic [11:0] OFS_MODE_HI  = 12'h004;
  localparam logic [11:0] OFS_CFG_45   = 12'h008;
  localparam logic [11:0] OFS_CFG_67   = 12'h00c;
  localparam logic [11:0] OFS_STATUS   = 12'h010;
  localparam logic [11:0] OFS_BANK     = 12'h040;
  localparam logic [11:0] BANK_SPAN    = 12'h100;

  // Reset values.
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [31:0] RDATA_NONE   = 32'h0000_0000;

  // Field positions inside a configuration or mode register.
  localparam int          CFG_HALF_W   = 4;
  localparam int          MODE_PAIR_W  = 2;

  // Scale code to compared width in bytes, three bits per code, code 0 lowest.
  localparam logic [11:0] SCALE_BYTES_DEFAULT = 12'h254;

  // One filter's half of a configuration register.
  typedef struct packed {
    logic       fifo_select;
    logic [1:0] scale_select;
    logic       filter_active;
  } cafc_fcfg_type;

  // One filter's pair of mode bits.
  typedef struct packed {
    logic high_half_list_mode;
    logic low_half_list_mode;
  } cafc_fmode_type;

  // Identifier presented by the receive logic.
  typedef struct packed {
    logic        valid;
    logic [31:0] ident;
  } cafc_probe_type;

  // Acceptance verdict returned to the receive logic.
  typedef struct packed {
    logic       valid;
    logic       accepted;
    logic       fifo_select;
    logic [7:0] matching_filter_index;
  } cafc_result_type;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MODE_LO,
    SEL_MODE_HI,
    SEL_CFG_45,
    SEL_CFG_67,
    SEL_STATUS,
    SEL_BANK
  } cafc_sel_type;

endpackage : cafc_pkg

// ==== src/cafc_filter_match.sv ====
// Comparator of one filter's eight bank bytes against an incoming identifier.
module cafc_filter_match (
  // Filter storage, byte i at bits 8*i+7 to 8*i.
  input  wire logic [63:0]             bank,
  // Filter setup.
  input  wire logic [2:0]              width_bytes,
  input  wire cafc_pkg::cafc_fmode_type fmode,
  input  wire logic                    active,
  // Incoming identifier, first byte in the top bits.
  input  wire logic [31:0]             ident,
  // Verdict.
  output logic                         hit
);

  function automatic logic [31:0] gather(input logic [63:0] b, input int start, input int w);
    logic [31:0] g;
    g = 32'h0000_0000;
    for (int k = 0; k < cafc_pkg::HALF_BYTES; k++) begin
      if (k < w) begin
        g[31 - 8 * k -: 8] = b[8 * (start + k) +: 8];
      end
    end
    return g;
  endfunction : gather

  // Mask bits of 1 force equality, 0 leaves the bit out; identifier 0 is dominant.
  function automatic logic slot_hit(input logic [31:0] id, input logic [31:0] exp_bits,
                                    input logic [31:0] mask_bits, input int w);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < cafc_pkg::HALF_BYTES; k++) begin
      if (k < w) begin
        if (((id[31 - 8 * k -: 8] ^ exp_bits[31 - 8 * k -: 8]) & mask_bits[31 - 8 * k -: 8])
            != 8'h00) begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction : slot_hit

  always_comb begin
    int  w;
    int  base;
    logic list;
    logic any;
    w    = int'(width_bytes);
    base = 0;
    list = 1'b0;
    any  = 1'b0;
    for (int h = 0; h < 2; h++) begin
      list = (h == 1) ? fmode.high_half_list_mode : fmode.low_half_list_mode;
      for (int s = 0; s < cafc_pkg::HALF_BYTES; s++) begin
        if (list) begin
          base = cafc_pkg::HALF_BYTES * h + s * w;
          if (s * w < cafc_pkg::HALF_BYTES) begin
            any = any | slot_hit(ident, gather(bank, base, w), 32'hffff_ffff, w);
          end
        end else if (w == cafc_pkg::HALF_BYTES) begin
          // A full-width mask needs the whole bank, so the high half masks the low half.
          if (h == 0 && s == 0) begin
            any = any | slot_hit(ident, gather(bank, 0, w), gather(bank, w, w), w);
          end
        end else begin
          base = cafc_pkg::HALF_BYTES * h + 2 * s * w;
          if (2 * s * w < cafc_pkg::HALF_BYTES) begin
            any = any | slot_hit(ident, gather(bank, base, w), gather(bank, base + w, w), w);
          end
        end
      end
    end
    hit = active & any;
  end

endmodule : cafc_filter_match

// ==== src/cafc_acceptance_filter.sv ====
// Acceptance filter configuration registers, filter banks and the acceptance decision.
//
// Summary of operation
// - Each configuration register holds two filters, odd filter high nibble, even low.
// - A filter's fifo_select bit routes its accepted messages to FIFO 0 or 1.
// - Each filter has a two-bit scale_select field shaping its bank comparison.
// - Only filters with filter_active set take part in acceptance.
// - Separate high and low half mode bits; 0 mask mode, 1 list mode.
// - Mode registers hold filters 0-3 and 4-7, higher filter high, high above low.
// - Each filter owns eight byte registers acting as mask or identifier.
// - An identifier bit of 0 expects dominant, 1 expects recessive.
// - A mask bit of 0 ignores that bit, 1 demands equality.
// - Mask bytes map to identifier positions exactly as list-mode identifier bytes do.
// - Configuration and mode registers reset to zero: inactive, mask mode, FIFO 0. Filters 0-3 take their setup from lower_cfg, which this block does not reset.
// - Filter bank bytes have no reset and hold garbage until written.
// - Configuration and mode bits change only through software writes.
// - The accepting filter's index is reported with each accepted message.
//
// The APB slave port and the address map were left to the implementer.
module cafc_acceptance_filter #(
  parameter logic [11:0] SCALE_BYTES = cafc_pkg::SCALE_BYTES_DEFAULT
) (
  // Clock and reset.
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // APB slave.
  input  wire logic [11:0]              paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Setup of filters 0 to 3, held in a register outside this block.
  input  wire cafc_pkg::cafc_fcfg_type  lower_cfg [4],
  // Identifier lookup from the receive logic.
  input  wire cafc_pkg::cafc_probe_type probe,
  output cafc_pkg::cafc_result_type     result
);

  // Every scale code must name a width of one, two or four bytes.
  for (genvar c = 0; c < 4; c++) begin : g_scale_check
    if (SCALE_BYTES[3 * c +: 3] != 3'd1 && SCALE_BYTES[3 * c +: 3] != 3'd2 &&
        SCALE_BYTES[3 * c +: 3] != 3'd4) begin : g_bad
      $error("Scale width table holds an unsupported width.");
    end
  end

  // Register state.
  logic [7:0]                filter_mode_zero_to_three_r;
  logic [7:0]                filter_mode_four_to_seven_r;
  logic [7:0]                filter_cfg_four_five_r;
  logic [7:0]                filter_cfg_six_seven_r;
  logic [7:0]                filter_bank_byte_r [cafc_pkg::BANK_TOTAL];
  logic [31:0]               prdata_r;
  logic                      pslverr_r;
  cafc_pkg::cafc_result_type result_r;

  // Decode helpers.
  cafc_pkg::cafc_sel_type    sel;
  logic [5:0]                bank_idx;
  logic                      wr_en;
  logic [31:0]               rd_nxt;
  logic                      err_nxt;

  // Acceptance helpers.
  logic [63:0]               bank_flat [cafc_pkg::NUM_FILTERS];
  cafc_pkg::cafc_fcfg_type   fcfg      [cafc_pkg::NUM_FILTERS];
  cafc_pkg::cafc_fmode_type  fmode     [cafc_pkg::NUM_FILTERS];
  logic [7:0]                hits;
  cafc_pkg::cafc_result_type result_nxt;

  function automatic cafc_pkg::cafc_sel_type decode(input logic [11:0] a);
    cafc_pkg::cafc_sel_type s;
    s = cafc_pkg::SEL_NONE;
    if (a[1:0] == 2'b00) begin
      if (a == cafc_pkg::OFS_MODE_LO) begin
        s = cafc_pkg::SEL_MODE_LO;
      end else if (a == cafc_pkg::OFS_MODE_HI) begin
        s = cafc_pkg::SEL_MODE_HI;
      end else if (a == cafc_pkg::OFS_CFG_45) begin
        s = cafc_pkg::SEL_CFG_45;
      end else if (a == cafc_pkg::OFS_CFG_67) begin
        s = cafc_pkg::SEL_CFG_67;
      end else if (a == cafc_pkg::OFS_STATUS) begin
        s = cafc_pkg::SEL_STATUS;
      end else if (a >= cafc_pkg::OFS_BANK &&
                   a < cafc_pkg::OFS_BANK + cafc_pkg::BANK_SPAN) begin
        s = cafc_pkg::SEL_BANK;
      end
    end
    return s;
  endfunction : decode

  function automatic logic [5:0] bank_index(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - cafc_pkg::OFS_BANK;
    return rel[7:2];
  endfunction : bank_index

  assign sel      = decode(paddr);
  assign bank_idx = bank_index(paddr);

  // Zero wait states: read data is latched in the setup cycle, so the access phase completes.
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign wr_en   = psel & penable & pwrite;

  always_comb begin
    rd_nxt  = cafc_pkg::RDATA_NONE;
    err_nxt = 1'b0;
    case (sel)
      cafc_pkg::SEL_MODE_LO: begin
        rd_nxt[7:0] = filter_mode_zero_to_three_r;
      end
      cafc_pkg::SEL_MODE_HI: begin
        rd_nxt[7:0] = filter_mode_four_to_seven_r;
      end
      cafc_pkg::SEL_CFG_45: begin
        rd_nxt[7:0] = filter_cfg_four_five_r;
      end
      cafc_pkg::SEL_CFG_67: begin
        rd_nxt[7:0] = filter_cfg_six_seven_r;
      end
      cafc_pkg::SEL_STATUS: begin
        rd_nxt[10:0] = {result_r.accepted, result_r.fifo_select,
                        result_r.matching_filter_index[7:0], 1'b0};
      end
      cafc_pkg::SEL_BANK: begin
        rd_nxt[7:0] = filter_bank_byte_r[bank_idx];
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_r  <= cafc_pkg::RDATA_NONE;
      pslverr_r <= 1'b0;
    end else if (psel & ~penable) begin
      prdata_r  <= pwrite ? cafc_pkg::RDATA_NONE : rd_nxt;
      pslverr_r <= err_nxt;
    end
  end

  // Mode registers; only a software write changes them.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filter_mode_zero_to_three_r <= cafc_pkg::MODE_RESET;
      filter_mode_four_to_seven_r <= cafc_pkg::MODE_RESET;
    end else if (wr_en) begin
      if (sel == cafc_pkg::SEL_MODE_LO) begin
        filter_mode_zero_to_three_r <= pwdata[7:0];
      end
      if (sel == cafc_pkg::SEL_MODE_HI) begin
        filter_mode_four_to_seven_r <= pwdata[7:0];
      end
    end
  end

  // Configuration registers. The init-mode restriction is software's to keep; the block
  // does not see the controller mode, so it accepts the write at any time.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filter_cfg_four_five_r <= cafc_pkg::CFG_RESET;
      filter_cfg_six_seven_r <= cafc_pkg::CFG_RESET;
    end else if (wr_en) begin
      if (sel == cafc_pkg::SEL_CFG_45) begin
        filter_cfg_four_five_r <= pwdata[7:0];
      end
      if (sel == cafc_pkg::SEL_CFG_67) begin
        filter_cfg_six_seven_r <= pwdata[7:0];
      end
    end
  end

  // Bank bytes carry no reset so they map onto plain RAM-like storage.
  always_ff @(posedge sys_clk) begin
    if (wr_en && sel == cafc_pkg::SEL_BANK) begin
      filter_bank_byte_r[bank_idx] <= pwdata[7:0];
    end
  end

  // Unpack per-filter fields.
  always_comb begin
    for (int f = 0; f < cafc_pkg::NUM_FILTERS; f++) begin
      for (int b = 0; b < cafc_pkg::BANK_BYTES; b++) begin
        bank_flat[f][8 * b +: 8] = filter_bank_byte_r[cafc_pkg::BANK_BYTES * f + b];
      end
      if (f < 4) begin
        fcfg[f]  = lower_cfg[f];
        fmode[f] = filter_mode_zero_to_three_r[cafc_pkg::MODE_PAIR_W * f +: 2];
      end else if (f < 6) begin
        fcfg[f]  = filter_cfg_four_five_r[cafc_pkg::CFG_HALF_W * (f - 4) +: 4];
        fmode[f] = filter_mode_four_to_seven_r[cafc_pkg::MODE_PAIR_W * (f - 4) +: 2];
      end else begin
        fcfg[f]  = filter_cfg_six_seven_r[cafc_pkg::CFG_HALF_W * (f - 6) +: 4];
        fmode[f] = filter_mode_four_to_seven_r[cafc_pkg::MODE_PAIR_W * (f - 4) +: 2];
      end
    end
  end

  for (genvar f = 0; f < cafc_pkg::NUM_FILTERS; f++) begin : g_filter
    cafc_filter_match u_match (
      .bank        (bank_flat[f]),
      .width_bytes (SCALE_BYTES[3 * fcfg[f].scale_select +: 3]),
      .fmode       (fmode[f]),
      .active      (fcfg[f].filter_active),
      .ident       (probe.ident),
      .hit         (hits[f])
    );
  end

  // Lowest-numbered matching filter wins when several match.
  always_comb begin
    result_nxt       = '0;
    result_nxt.valid = probe.valid;
    for (int f = cafc_pkg::NUM_FILTERS - 1; f >= 0; f--) begin
      if (hits[f]) begin
        result_nxt.accepted              = 1'b1;
        result_nxt.fifo_select           = fcfg[f].fifo_select;
        result_nxt.matching_filter_index = 8'(f);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_r <= '0;
    end else if (probe.valid) begin
      result_r <= result_nxt;
    end else begin
      result_r.valid <= 1'b0;
    end
  end

  assign result = result_r;

endmodule : cafc_acceptance_filter

// ==== testbench/cafc_acceptance_filter_sva.sv ====
// Checker of the acceptance filter block's bus answers and lookup timing.
module cafc_acceptance_filter_sva (
  // Clock and reset.
  input wire logic                      sys_clk,
  input wire logic                      rst,
  // Register bus.
  input wire logic [11:0]               paddr,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Lookup.
  input wire cafc_pkg::cafc_probe_type  probe,
  input wire cafc_pkg::cafc_result_type result
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = psel & penable;
  AST_RESULT_LATENCY: assert property (probe.valid |=> result.valid)
    else $error("Lookup answer missing one cycle after request.");
  AST_RESULT_CAUSE: assert property (result.valid |-> $past(probe.valid))
    else $error("Lookup answer without request.");
  AST_NO_MATCH_FIELDS: assert property (result.valid && !result.accepted |->
    !result.fifo_select && result.matching_filter_index == 8'h00)
    else $error("Rejected lookup carries routing fields.");
  AST_INDEX_RANGE: assert property (result.valid && result.accepted |->
    result.matching_filter_index < 8'h08)
    else $error("Matching index out of range.");
  AST_FIELDS_HOLD: assert property (!result.valid |->
    $stable({result.accepted, result.fifo_select, result.matching_filter_index}))
    else $error("Lookup fields changed without request.");
  AST_ACCESS_READY: assert property (acc |-> pready)
    else $error("Access phase not answered.");
  AST_MISALIGNED_ERR: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("Misaligned access not refused.");
  AST_ERR_READS_ZERO: assert property (acc && !pwrite && pslverr |->
    prdata == 32'h0000_0000)
    else $error("Refused read returns data.");
  AST_UPPER_ZERO: assert property (acc && !pwrite |-> prdata[31:11] == 21'h00_0000)
    else $error("Read data above the register width.");
endmodule : cafc_acceptance_filter_sva

// ==== testbench/tb_top.sv ====
// Testbench of the acceptance filter block: register access and lookups.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] REGS [4] = '{cafc_pkg::OFS_MODE_LO, cafc_pkg::OFS_MODE_HI,
                                       cafc_pkg::OFS_CFG_45, cafc_pkg::OFS_CFG_67};
  // Filters 4, 5 and 6 bank images, eight bytes each.
  localparam logic [7:0]  IMG [24] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hff, 8'hff, 8'hff, 8'h00,
                                       8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h01, 8'h02, 8'h03, 8'h04,
                                       8'hab, 8'hcd, 8'hff, 8'h00, 8'hab, 8'hcd, 8'hff, 8'hff};
  logic                      sys_clk;
  logic                      rst;
  logic [11:0]               paddr;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  cafc_pkg::cafc_fcfg_type   lower_cfg [4];
  cafc_pkg::cafc_probe_type  probe;
  cafc_pkg::cafc_result_type result;
  logic [31:0]               rdat;
  logic                      rerr;
  int                        errors;
  int                        num_checks;
  int                        cycles;

  cafc_acceptance_filter i_dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lower_cfg(lower_cfg), .probe(probe), .result(result));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // The run is a few hundred cycles; the ceiling leaves ample slack.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One edge first, so a release and the next setup never share a time step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rdchk

  task automatic look(input logic [31:0] id, input logic [10:0] exp);
    @(posedge sys_clk);
    probe <= {1'b1, id};
    @(posedge sys_clk);
    probe <= '0;
    #1;
    chk({21'h0, result}, {21'h0, exp});
  endtask : look

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    probe = '0;
    lower_cfg = '{default: 4'h0};
    errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rdchk(REGS[i], 32'h0000_0000);
      apb(1'b1, REGS[i], 32'hffff_ff5a + i);
      rdchk(REGS[i], 32'h0000_005a + i);
      apb(1'b1, REGS[i], 32'h0000_0000);
    end
    for (int i = 0; i < 24; i++) begin
      apb(1'b1, 12'h0c0 + 12'(4 * i), {24'hffffff, IMG[i]});
      rdchk(12'h0c0 + 12'(4 * i), {24'h0, IMG[i]});
    end
    apb(1'b1, cafc_pkg::OFS_MODE_HI, 32'h0000_000c);
    look(32'h1234_5699, 11'h400);
    apb(1'b1, cafc_pkg::OFS_CFG_45, 32'h0000_0019);
    apb(1'b1, cafc_pkg::OFS_CFG_67, 32'h0000_0003);
    look(32'h1234_5699, 11'h704);
    look(32'h1234_5799, 11'h400);
    look(32'ha1b2_c3d4, 11'h605);
    look(32'ha1b2_c3d5, 11'h400);
    look(32'h0102_0304, 11'h605);
    rdchk(cafc_pkg::OFS_STATUS, 32'h0000_040a);
    apb(1'b1, cafc_pkg::OFS_STATUS, 32'h0000_0000);
    rdchk(cafc_pkg::OFS_STATUS, 32'h0000_040a);
    look(32'hab99_0000, 11'h606);
    look(32'hac00_0000, 11'h400);
    // Filter 4 in list mode now wants the whole identifier.
    apb(1'b1, cafc_pkg::OFS_MODE_HI, 32'h0000_000f);
    look(32'h1234_5699, 11'h400);
    look(32'h1234_5678, 11'h704);
    apb(1'b1, cafc_pkg::OFS_CFG_45, 32'h0000_0018);
    @(posedge sys_clk);
    probe <= {1'b1, 32'ha1b2_c3d4};
    @(posedge sys_clk);
    probe <= {1'b1, 32'h1234_5678};
    #1 chk({21'h0, result}, {21'h0, 11'h605});
    @(posedge sys_clk);
    probe <= '0;
    #1 chk({21'h0, result}, {21'h0, 11'h400});
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    apb(1'b1, 12'h005, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    rdchk(cafc_pkg::OFS_MODE_HI, 32'h0000_000f);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk({21'h0, result}, 32'h0000_0000);
    rdchk(cafc_pkg::OFS_CFG_45, 32'h0000_0000);
    rdchk(cafc_pkg::OFS_MODE_HI, 32'h0000_0000);
    rdchk(cafc_pkg::OFS_BANK + 12'h080, 32'h0000_0012);
    // Filter 0 gets filter 4's image while inactive; with both matching, the lower index wins.
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, cafc_pkg::OFS_BANK + 12'(4 * i), {24'h0, IMG[i]});
    end
    apb(1'b1, cafc_pkg::OFS_CFG_45, 32'h0000_0009);
    lower_cfg[0] <= 4'h9;
    look(32'h1234_5699, 11'h700);
    // One-byte list mode on filter 0 reaches scale code 2, one of the two codes that pick single bytes.
    apb(1'b1, cafc_pkg::OFS_MODE_LO, 32'h0000_0003);
    lower_cfg[0] <= 4'hd;
    look(32'h7800_0000, 11'h700);
    look(32'h7900_0000, 11'h400);
    final_report();
  end
endmodule : tb_top

bind cafc_acceptance_filter cafc_acceptance_filter_sva i_sva (.sys_clk(sys_clk), .rst(rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .probe(probe), .result(result));
